// *** hcd_consts.svh ***
// constants for the hall commutation drive
// Contract
// - the run lamp is on while the motor runs and off while it is stopped.
// - the fault lamp is on while an error is held and off in normal operation.
// - a press of the fault clear button leaves the error state for normal operation.
// - the run toggle switch is the start and stop command of the motor.
// - a low switch level requests start and a change to high requests stop.
// - the three high side gate outputs are active low.
// - the three low side gate outputs are active high.
// - high and low side gating is complementary with dead time from an up/down carrier.
// - an overcurrent falling edge or an output short puts all six gate pins in high impedance.
// - each of the three hall inputs raises an event on both edges.
// - each hall event samples the speed timer, reads hall levels and updates the pattern.
// - while running, 200 ms without a hall event flags an error and stops the drive.
// - compare match channel 0 gives a periodic event every 1 ms.
// - compare match channel 1 free runs for speed measurement with no interrupt.
// - speed command, three currents and bus voltage are converted in one hardware triggered scan.
`ifndef HCD_CONSTS_SVH
`define HCD_CONSTS_SVH
`define HCD_CLK_PERIOD_NS   50
`define HCD_TICK_NS         1000000
`define HCD_TICK_CYCLES     (`HCD_TICK_NS / `HCD_CLK_PERIOD_NS)
`define HCD_TIMEOUT_MS      200
`define HCD_CARRIER_NS      50000
`define HCD_PWM_HALF        10'((`HCD_CARRIER_NS / `HCD_CLK_PERIOD_NS) / 2)
`define HCD_ADC_CHANNELS    5
`define HCD_SYNC_RESET      7'h38
`define HCD_REG_CTRL        8'h00
`define HCD_REG_DUTY        8'h04
`define HCD_REG_DEADTIME    8'h08
`define HCD_REG_STATUS      8'h0c
`define HCD_REG_MASK        8'h10
`define HCD_REG_STATE       8'h14
`define HCD_REG_SPEED_PER   8'h18
`define HCD_REG_SPEED_TMR   8'h1c
`define HCD_REG_ADC_BASE    8'h20
`define HCD_DUTY_RESET      10'h000
`define HCD_DEADTIME_RESET  8'h14
`define HCD_ST_HALL_EDGE    0
`define HCD_ST_TICK         1
`define HCD_ST_SCAN_DONE    2
`define HCD_ST_OVERCURRENT  3
`define HCD_ST_SHORT        4
`define HCD_ST_TIMEOUT      5
`define HCD_ST_HALL_BAD     6
`define HCD_STATUS_BITS     7
`endif

// *** hcd_pkg.sv ***
// types for the hall commutation drive
package hcd_pkg;
    typedef enum logic [1:0] {hcd_stop, hcd_run, hcd_error} hcd_state_t;
    typedef enum logic [1:0] {hcd_off, hcd_pwm, hcd_low} hcd_drive_t;
    typedef enum logic [1:0] {hcd_idle, hcd_hold, hcd_conv} hcd_scan_t;
endpackage

// *** hcd_drive.sv ***
// hall commutation drive: gating, protection, timers, conversion scan, panel
`timescale 1ns/1ps
`include "hcd_consts.svh"
module hcd_drive #(
    parameter int unsigned TICK_CYCLES = `HCD_TICK_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic [7:0]        addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic [31:0]            rdata,
    output logic                   irq,
    input  wire logic              run_toggle_switch,
    input  wire logic              fault_clear_button_n,
    output logic                   run_lamp,
    output logic                   fault_lamp,
    input  wire logic              overcurrent_stop_n,
    input  wire logic              output_short,
    input  wire logic              hall_phase_a,
    input  wire logic              hall_phase_b,
    input  wire logic              hall_phase_c,
    output logic                   high_side_a_gate_n,
    output logic                   high_side_b_gate_n,
    output logic                   high_side_c_gate_n,
    output logic                   low_side_a_gate,
    output logic                   low_side_b_gate,
    output logic                   low_side_c_gate,
    output logic                   gate_oe,
    output logic                   adc_sample_hold,
    output logic                   adc_start,
    output logic [2:0]             adc_channel,
    input  wire logic              adc_done,
    input  wire logic [11:0]       adc_data
);
    import hcd_pkg::*;

    // pattern for one phase; reverse swaps the driven and sinking phase
    function automatic hcd_drive_t phase_drive(input logic [2:0] hall, input logic rev, input int ph);
        logic [1:0] src;
        logic [1:0] snk;
        hcd_drive_t d;
        src = 2'd3;
        snk = 2'd3;
        case (hall)
            3'h1: begin src = 2'd0; snk = 2'd1; end
            3'h3: begin src = 2'd0; snk = 2'd2; end
            3'h2: begin src = 2'd1; snk = 2'd2; end
            3'h6: begin src = 2'd1; snk = 2'd0; end
            3'h4: begin src = 2'd2; snk = 2'd0; end
            3'h5: begin src = 2'd2; snk = 2'd1; end
            default: begin src = 2'd3; snk = 2'd3; end
        endcase
        d = hcd_off;
        if (int'(rev ? snk : src) == ph) begin
            d = hcd_pwm;
        end else if (int'(rev ? src : snk) == ph) begin
            d = hcd_low;
        end
        return d;
    endfunction

    function automatic logic hall_valid(input logic [2:0] hall);
        return (hall != 3'h0) && (hall != 3'h7);
    endfunction

    // two-flop synchronisers for the panel, protection and hall inputs; the converter inputs are not synchronised
    logic [6:0]  raw;
    logic [6:0]  sync1;
    logic [6:0]  sync2;
    logic [6:0]  sync3;
    assign raw = {output_short, overcurrent_stop_n, fault_clear_button_n, run_toggle_switch,
                  hall_phase_c, hall_phase_b, hall_phase_a};
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync1 <= `HCD_SYNC_RESET;
            sync2 <= `HCD_SYNC_RESET;
            sync3 <= `HCD_SYNC_RESET;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    logic [2:0]  hall_now;
    logic        hall_edge;
    logic        run_req;
    logic        clear_press;
    logic        ocp_fall;
    logic        short_event;
    assign hall_now    = sync2[2:0];
    assign hall_edge   = |(sync2[2:0] ^ sync3[2:0]);
    assign run_req     = !sync2[3];
    assign clear_press = !sync2[4] && sync3[4];
    assign ocp_fall    = !sync2[5] && sync3[5];
    assign short_event = sync2[6] && !sync3[6];

    // software registers
    logic                        ctrl_reverse;
    logic [9:0]                  duty;
    logic [7:0]                  deadtime;
    logic [`HCD_STATUS_BITS-1:0] status;
    logic [`HCD_STATUS_BITS-1:0] mask;
    logic [`HCD_STATUS_BITS-1:0] events;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_reverse <= 1'b0;
            duty         <= `HCD_DUTY_RESET;
            deadtime     <= `HCD_DEADTIME_RESET;
            mask         <= '0;
        end else if (wr) begin
            if (addr == `HCD_REG_CTRL) begin
                ctrl_reverse <= wdata[0];
            end else if (addr == `HCD_REG_DUTY) begin
                duty <= wdata[9:0];
            end else if (addr == `HCD_REG_DEADTIME) begin
                deadtime <= wdata[7:0];
            end else if (addr == `HCD_REG_MASK) begin
                mask <= wdata[`HCD_STATUS_BITS-1:0];
            end
        end
    end

    // sticky status; a new event wins over a write-one clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            status <= '0;
        end else if (wr && addr == `HCD_REG_STATUS) begin
            status <= (status & ~wdata[`HCD_STATUS_BITS-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end
    assign irq = |(status & mask);

    // compare match channel 0: 1 ms tick
    logic [31:0] tick_cnt;
    logic        tick;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else if (tick_cnt == TICK_CYCLES - 1) begin
            tick_cnt <= '0;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'd1;
            tick     <= 1'b0;
        end
    end

    // compare match channel 1: free running, raises no status bit
    logic [15:0] speed_tmr;
    logic [15:0] speed_cap;
    logic [15:0] speed_per;
    logic [2:0]  hall_pos;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            speed_tmr <= '0;
        end else begin
            speed_tmr <= speed_tmr + 16'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            speed_cap <= '0;
            speed_per <= '0;
            hall_pos  <= '0;
        end else if (hall_edge) begin
            speed_cap <= speed_tmr;
            speed_per <= speed_tmr - speed_cap;
            hall_pos  <= hall_now;
        end
    end

    // drive state and protection
    hcd_state_t  state;
    logic        hiz;
    logic [7:0]  idle_ms;
    logic        timeout;
    logic        hall_bad;
    logic        fault;
    assign timeout  = (state == hcd_run) && (idle_ms == 8'(`HCD_TIMEOUT_MS));
    assign hall_bad = (state == hcd_run) && hall_edge && !hall_valid(hall_now);
    assign fault    = timeout || hall_bad || ocp_fall || short_event;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            idle_ms <= '0;
        end else if (state != hcd_run || hall_edge) begin
            idle_ms <= '0;
        end else if (tick && !timeout) begin
            idle_ms <= idle_ms + 8'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hiz <= 1'b0;
        end else if (ocp_fall || short_event) begin
            hiz <= 1'b1;
        end else if (state == hcd_error && clear_press) begin
            hiz <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= hcd_stop;
        end else begin
            case (state)
                hcd_stop: begin
                    if (fault) begin
                        state <= hcd_error;
                    end else if (run_req && hall_valid(hall_now)) begin
                        state <= hcd_run;
                    end
                end
                hcd_run: begin
                    if (fault) begin
                        state <= hcd_error;
                    end else if (!run_req) begin
                        state <= hcd_stop;
                    end
                end
                default: begin
                    // a fault in the clearing cycle keeps the error
                    if (clear_press && !fault) begin
                        state <= hcd_stop;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            run_lamp   <= 1'b0;
            fault_lamp <= 1'b0;
        end else begin
            run_lamp   <= (state == hcd_run);
            fault_lamp <= (state == hcd_error);
        end
    end

    // triangle carrier, counts 0 up to half and back
    logic [9:0]  carrier;
    logic        down;
    logic        pwm_on;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            carrier <= '0;
            down    <= 1'b0;
        end else if (!down) begin
            carrier <= carrier + 10'd1;
            down    <= (carrier == `HCD_PWM_HALF - 10'd1);
        end else begin
            carrier <= carrier - 10'd1;
            down    <= (carrier != 10'd1);
        end
    end
    assign pwm_on = carrier < duty;

    // per-phase complementary gating with dead time
    logic [2:0]  hi_on;
    logic [2:0]  lo_on;
    for (genvar i = 0; i < 3; i++) begin : g_phase
        hcd_drive_t drv;
        logic       want_hi;
        logic       want_lo;
        logic       prev_hi;
        logic       prev_lo;
        logic [7:0] dt;
        logic       hi_q;
        logic       lo_q;
        assign drv     = phase_drive(hall_pos, ctrl_reverse, i);
        assign want_hi = (state == hcd_run) && drv == hcd_pwm && pwm_on;
        assign want_lo = (state == hcd_run) && (drv == hcd_low || (drv == hcd_pwm && !pwm_on));
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                prev_hi <= 1'b0;
                prev_lo <= 1'b0;
                dt      <= '0;
                hi_q    <= 1'b0;
                lo_q    <= 1'b0;
            end else begin
                prev_hi <= want_hi;
                prev_lo <= want_lo;
                // turn-off is immediate, turn-on waits out the dead time
                if (want_hi != prev_hi || want_lo != prev_lo) begin
                    dt   <= deadtime;
                    hi_q <= 1'b0;
                    lo_q <= 1'b0;
                end else if (dt != 8'h00) begin
                    dt   <= dt - 8'd1;
                    hi_q <= 1'b0;
                    lo_q <= 1'b0;
                end else begin
                    hi_q <= want_hi;
                    lo_q <= want_lo;
                end
            end
        end
        assign hi_on[i] = hi_q;
        assign lo_on[i] = lo_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            high_side_a_gate_n <= 1'b1;
            high_side_b_gate_n <= 1'b1;
            high_side_c_gate_n <= 1'b1;
            low_side_a_gate    <= 1'b0;
            low_side_b_gate    <= 1'b0;
            low_side_c_gate    <= 1'b0;
            gate_oe            <= 1'b1;
        end else begin
            high_side_a_gate_n <= !hi_on[0];
            high_side_b_gate_n <= !hi_on[1];
            high_side_c_gate_n <= !hi_on[2];
            low_side_a_gate    <= lo_on[0];
            low_side_b_gate    <= lo_on[1];
            low_side_c_gate    <= lo_on[2];
            gate_oe            <= !hiz && !ocp_fall && !short_event;
        end
    end

    // single scan of five channels, started at the carrier peak
    hcd_scan_t   scan;
    logic [2:0]  scan_idx;
    logic        scan_done;
    logic [11:0] adc_res [`HCD_ADC_CHANNELS];
    logic        trigger;
    assign trigger = down && carrier == `HCD_PWM_HALF;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            scan            <= hcd_idle;
            scan_idx        <= '0;
            scan_done       <= 1'b0;
            adc_sample_hold <= 1'b0;
            adc_start       <= 1'b0;
            adc_channel     <= '0;
            for (int k = 0; k < `HCD_ADC_CHANNELS; k++) begin
                adc_res[k] <= '0;
            end
        end else begin
            adc_sample_hold <= 1'b0;
            adc_start       <= 1'b0;
            scan_done       <= 1'b0;
            case (scan)
                hcd_idle: begin
                    // a trigger during a running scan is dropped
                    if (trigger) begin
                        adc_sample_hold <= 1'b1;
                        scan_idx        <= '0;
                        scan            <= hcd_hold;
                    end
                end
                hcd_hold: begin
                    adc_start   <= 1'b1;
                    adc_channel <= scan_idx;
                    scan        <= hcd_conv;
                end
                default: begin
                    if (adc_done) begin
                        adc_res[scan_idx] <= adc_data;
                        if (scan_idx == 3'(`HCD_ADC_CHANNELS - 1)) begin
                            scan_done <= 1'b1;
                            scan      <= hcd_idle;
                        end else begin
                            scan_idx <= scan_idx + 3'd1;
                            scan     <= hcd_hold;
                        end
                    end
                end
            endcase
        end
    end

    always_comb begin
        events = '0;
        events[`HCD_ST_HALL_EDGE]   = hall_edge;
        events[`HCD_ST_TICK]        = tick;
        events[`HCD_ST_SCAN_DONE]   = scan_done;
        events[`HCD_ST_OVERCURRENT] = ocp_fall;
        events[`HCD_ST_SHORT]       = short_event;
        events[`HCD_ST_TIMEOUT]     = timeout;
        events[`HCD_ST_HALL_BAD]    = hall_bad;
    end

    // read port, data one cycle after the strobe
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = '0;
        if (addr == `HCD_REG_CTRL) begin
            next_rdata = {31'h0, ctrl_reverse};
        end else if (addr == `HCD_REG_DUTY) begin
            next_rdata = {22'h0, duty};
        end else if (addr == `HCD_REG_DEADTIME) begin
            next_rdata = {24'h0, deadtime};
        end else if (addr == `HCD_REG_STATUS) begin
            next_rdata = {25'h0, status};
        end else if (addr == `HCD_REG_MASK) begin
            next_rdata = {25'h0, mask};
        end else if (addr == `HCD_REG_STATE) begin
            next_rdata = {24'h0, hiz, hall_pos, 2'h0, state};
        end else if (addr == `HCD_REG_SPEED_PER) begin
            next_rdata = {16'h0, speed_per};
        end else if (addr == `HCD_REG_SPEED_TMR) begin
            next_rdata = {16'h0, speed_tmr};
        end else if (addr >= `HCD_REG_ADC_BASE && addr < `HCD_REG_ADC_BASE + 8'd20 && addr[1:0] == 2'h0) begin
            next_rdata = {20'h0, adc_res[3'(addr[4:2])]};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata <= '0;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= '0;
        end
    end
endmodule // hcd_drive

// *** hcd_drive_properties.sv ***
// concurrent checks on the ports of the hall commutation drive
`timescale 1ns/1ps
module hcd_checker (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        run_toggle_switch,
    input wire logic        fault_clear_button_n,
    input wire logic        overcurrent_stop_n,
    input wire logic        run_lamp,
    input wire logic        fault_lamp,
    input wire logic        gate_oe,
    input wire logic [2:0]  hs_n,
    input wire logic [2:0]  ls,
    input wire logic        adc_sample_hold,
    input wire logic        adc_start,
    input wire logic [2:0]  adc_channel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
        else $error("read data not zero outside the answer cycle");
    a_ocp_hiz: assert property ($fell(overcurrent_stop_n) |-> ##[1:5] !gate_oe)
        else $error("gates not released after overcurrent");
    a_fault_lamp_on: assert property ($fell(overcurrent_stop_n) |-> ##[2:7] fault_lamp)
        else $error("fault lamp not lit after overcurrent");
    a_hiz_hold: assert property ($rose(gate_oe) |-> !$past(fault_clear_button_n, 4))
        else $error("gates driven again without a clear press");
    a_lamps_apart: assert property (!(run_lamp && fault_lamp))
        else $error("run and fault lamp lit together");
    a_off_stopped: assert property (!run_lamp && !$past(run_lamp) |-> hs_n == 3'h7 && ls == 3'h0)
        else $error("gates on while stopped");
    a_no_overlap: assert property ((~hs_n & ls) == 3'h0)
        else $error("high and low gate of one phase on together");
    a_dead_time: assert property ($fell(ls[2]) |=> hs_n[2] [*8])
        else $error("high gate on inside dead time");
    a_scan_first: assert property (adc_sample_hold |=> adc_start && adc_channel == 3'h0)
        else $error("scan does not start with channel zero");
    a_start_pulse: assert property (adc_start |=> !adc_start)
        else $error("conversion start longer than one cycle");
    a_run_start: assert property ($rose(run_lamp) |-> !$past(run_toggle_switch, 3))
        else $error("motor started without a low switch level");
endmodule // hcd_checker
bind hcd_drive hcd_checker chk_u (
    .clk(clk), .rst_b(rst_b), .rd(rd), .rdata(rdata), .run_toggle_switch(run_toggle_switch),
    .fault_clear_button_n(fault_clear_button_n), .overcurrent_stop_n(overcurrent_stop_n),
    .run_lamp(run_lamp), .fault_lamp(fault_lamp), .gate_oe(gate_oe),
    .hs_n({high_side_c_gate_n, high_side_b_gate_n, high_side_a_gate_n}),
    .ls({low_side_c_gate, low_side_b_gate, low_side_a_gate}),
    .adc_sample_hold(adc_sample_hold), .adc_start(adc_start), .adc_channel(adc_channel));

// *** hcd_bridge_model.sv ***
// converter model of the far side, answering each start after a delay
`timescale 1ns/1ps
module hcd_bridge_model #(
    parameter int unsigned DELAY = 6
) (
    input  wire logic        clk,
    input  wire logic        adc_start,
    input  wire logic [2:0]  adc_channel,
    output logic             adc_done,
    output logic [11:0]      adc_data
);
    int unsigned cnt = 0;
    logic [2:0]  ch = 3'h0;
    initial adc_done = 1'b0;
    initial adc_data = 12'h000;
    always @(posedge clk) begin
        adc_done <= 1'b0;
        // data not valid: never repeat the last value
        adc_data <= ~adc_data;
        if (adc_start) begin
            cnt <= DELAY;
            ch <= adc_channel;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                adc_done <= 1'b1;
                adc_data <= 12'h3a0 + 12'(ch);
            end
        end
    end
endmodule // hcd_bridge_model

// *** hcd_tb.sv ***
// self-checking bench for the hall commutation drive
`timescale 1ns/1ps
`include "hcd_consts.svh"
module testbench;
    import hcd_pkg::*;
    localparam int unsigned TICKS = 20;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0, rd = 1'b0, sw = 1'b1, btn_n = 1'b1, ocp_n = 1'b1, short_pin = 1'b0;
    logic [2:0]  hall = 3'h0;
    logic [31:0] rdata, v, t0;
    logic        irq, run_lamp, fault_lamp, gate_oe, adc_sh, adc_start, adc_done;
    logic [2:0]  hs_n, ls, adc_ch;
    logic [11:0] adc_data;
    int          num_errors = 0, checked = 0, cycles = 0, n;
    always #25 clk = ~clk;
    hcd_drive #(.TICK_CYCLES(TICKS)) dut_u (
        .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .run_toggle_switch(sw), .fault_clear_button_n(btn_n), .run_lamp(run_lamp), .fault_lamp(fault_lamp),
        .overcurrent_stop_n(ocp_n), .output_short(short_pin),
        .hall_phase_a(hall[0]), .hall_phase_b(hall[1]), .hall_phase_c(hall[2]),
        .high_side_a_gate_n(hs_n[0]), .high_side_b_gate_n(hs_n[1]), .high_side_c_gate_n(hs_n[2]),
        .low_side_a_gate(ls[0]), .low_side_b_gate(ls[1]), .low_side_c_gate(ls[2]), .gate_oe(gate_oe),
        .adc_sample_hold(adc_sh), .adc_start(adc_start), .adc_channel(adc_ch),
        .adc_done(adc_done), .adc_data(adc_data));
    hcd_bridge_model #(.DELAY(6)) bridge_u (
        .clk(clk), .adc_start(adc_start), .adc_channel(adc_ch), .adc_done(adc_done), .adc_data(adc_data));
    task automatic give_verdict();
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        // rdata stands for this one cycle only; take it at the edge that ends it
        @(posedge clk);
        d = rdata;
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        rd_reg(a, v);
        check(what, v, exp);
    endtask
    task automatic poll(input int b, input int lim);
        v = 32'h0000_0000;
        for (int i = 0; i < lim && v[b] !== 1'b1; i++) rd_reg(`HCD_REG_STATUS, v);
        check("status bit", 32'(v[b]), 32'h0000_0001);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic press();
        @(posedge clk);
        btn_n <= 1'b0;
        cyc(10);
        btn_n <= 1'b1;
        cyc(6);
    endtask
    always @(posedge clk) begin
        cycles++;
        // a hang costs one mismatch and still reports
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        cyc(5);
        rst_b <= 1'b1;
        chk(`HCD_REG_DUTY, 32'h0000_0000, "duty reset");
        chk(`HCD_REG_DEADTIME, 32'h0000_0014, "dead time reset");
        chk(`HCD_REG_STATE, 32'h0000_0000, "state reset");
        wr_reg(8'h40, 32'hffff_ffff);
        chk(8'h40, 32'h0000_0000, "unmapped");
        chk(8'h06, 32'h0000_0000, "unaligned");
        wr_reg(`HCD_REG_DUTY, 32'h0000_f0c8);
        chk(`HCD_REG_DUTY, 32'h0000_00c8, "duty");
        rd_reg(`HCD_REG_SPEED_TMR, t0);
        rd_reg(`HCD_REG_SPEED_TMR, v);
        check("speed timer", 32'(16'(v[15:0] - t0[15:0])), 32'h0000_0003);
        wr_reg(`HCD_REG_MASK, 32'h0000_0002);
        // first pass lines up with a tick, second pass times the period less the two write cycles
        repeat (2) begin
            wr_reg(`HCD_REG_STATUS, 32'h0000_0002);
            n = 0;
            #1;
            while (irq !== 1'b1 && n < 100) begin @(posedge clk); #1 n++; end
        end
        check("tick period", 32'(n), 32'(TICKS - 2));
        wr_reg(`HCD_REG_MASK, 32'h0000_0000);
        #1 check("masked irq", 32'(irq), 32'h0000_0000);
        poll(`HCD_ST_SCAN_DONE, 800);
        for (int i = 0; i < 5; i++) chk(8'(`HCD_REG_ADC_BASE + 4 * i), 32'h0000_03a0 + i, "adc result");
        hall <= 3'b010;
        sw <= 1'b0;
        cyc(10);
        check("run lamp", 32'(run_lamp), 32'h0000_0001);
        chk(`HCD_REG_STATE, 32'h0000_0021, "state run");
        cyc(40);
        check("gates b+c-", 32'({hs_n[0], ls[0], hs_n[2], ls[2]}), 32'h0000_000b);
        hall <= 3'b110;
        cyc(100);
        hall <= 3'b100;
        cyc(100);
        hall <= 3'b101;
        cyc(40);
        chk(`HCD_REG_SPEED_PER, 32'h0000_0064, "speed period");
        check("gates c+b-", 32'({hs_n[0], ls[0], hs_n[1], ls[1]}), 32'h0000_000b);
        poll(`HCD_ST_HALL_EDGE, 2);
        wr_reg(`HCD_REG_CTRL, 32'h0000_0001);
        chk(`HCD_REG_CTRL, 32'h0000_0001, "reverse");
        cyc(40);
        check("gates b+c- reverse", 32'({hs_n[0], ls[0], hs_n[2], ls[2]}), 32'h0000_000b);
        wr_reg(`HCD_REG_CTRL, 32'h0000_0000);
        sw <= 1'b1;
        cyc(10);
        check("stopped", 32'({run_lamp, hs_n, ls}), 32'h0000_0038);
        sw <= 1'b0;
        poll(`HCD_ST_TIMEOUT, 2500);
        cyc(3);
        check("timeout lamps", 32'({run_lamp, fault_lamp}), 32'h0000_0001);
        sw <= 1'b1;
        press();
        check("fault cleared", 32'(fault_lamp), 32'h0000_0000);
        sw <= 1'b0;
        cyc(10);
        ocp_n <= 1'b0;
        cyc(5);
        check("ocp hiz", 32'(gate_oe), 32'h0000_0000);
        ocp_n <= 1'b1;
        cyc(50);
        chk(`HCD_REG_STATE, 32'h0000_00d2, "hiz held");
        sw <= 1'b1;
        press();
        check("ocp clear", 32'({gate_oe, fault_lamp}), 32'h0000_0002);
        short_pin <= 1'b1;
        cyc(5);
        check("short hiz", 32'(gate_oe), 32'h0000_0000);
        poll(`HCD_ST_SHORT, 2);
        wr_reg(`HCD_REG_STATUS, 32'h0000_0010);
        rd_reg(`HCD_REG_STATUS, v);
        check("short cleared", 32'(v[4]), 32'h0000_0000);
        short_pin <= 1'b0;
        press();
        check("short clear", 32'(gate_oe), 32'h0000_0001);
        give_verdict();
    end
endmodule // testbench
